//--- hw/i2cbr_map.vh
`ifndef I2CBR_MAP_VH
`define I2CBR_MAP_VH
// Register byte addresses
`define I2CBR_ADDR_RELOAD   8'h00
`define I2CBR_ADDR_CONTROL  8'h04
`define I2CBR_ADDR_STATUS   8'h08
`define I2CBR_ADDR_IRQSTAT  8'h0c
`define I2CBR_ADDR_IRQMASK  8'h10
`define I2CBR_ADDR_BUFFER   8'h14
// Control bits (self clearing sequence enables)
`define I2CBR_CTL_RSTART    0
`define I2CBR_CTL_STOP      1
// Status bits of i2c_port_status
`define I2CBR_ST_BUSY       0
`define I2CBR_ST_STOPSEEN   4
`define I2CBR_ST_RSTART     1
`define I2CBR_ST_STOPRUN    2
// Interrupt bits
`define I2CBR_IRQ_COLL      0
`define I2CBR_IRQ_DONE      1
`define I2CBR_IRQ_W         2
// Reset value and AXI response codes
`define I2CBR_RELOAD_RST    8'h13
`define I2CBR_AXI_OKAY      2'b00
`define I2CBR_AXI_SLVERR    2'b10
`endif

//--- hw/i2cbr_baud_counter.v
`timescale 1ns/1ps
// Reloadable down-counter; each expiry marks one half period of the serial clock
module i2cbr_baud_counter #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // Control
  input  wire             reload,
  input  wire             run,
  input  wire [WIDTH-1:0] reloadValue,
  // Status
  output reg              expired
);
  reg [WIDTH-1:0] count;
  reg [1:0]       phase;

  // Two system ticks per counter step, so a half period is 2*(value+1) ticks
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      count   <= {WIDTH{1'b0}};
      phase   <= 2'b00;
      expired <= 1'b0;
    end else if (reload) begin
      count   <= reloadValue;
      phase   <= 2'b00;
      expired <= 1'b0;
    end else if (run && !expired) begin
      phase <= phase + 2'b01;
      if (phase == 2'b01) begin
        phase <= 2'b00;
        if (count == {WIDTH{1'b0}})
          expired <= 1'b1;
        else
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- hw/i2cbr_master.v
`timescale 1ns/1ps
`include "i2cbr_map.vh"
module i2cbr_master #(
  parameter BAUD_W = 8
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // AXI4-Lite write
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // I2C pins, open drain
  input  wire        sclIn,
  output wire        sclOut,
  output reg         sclOe,
  input  wire        sdaIn,
  output wire        sdaOut,
  output reg         sdaOe,
  // Interrupt
  output wire        irq
);
  localparam ST_IDLE   = 4'd0;
  localparam ST_RS_CNT = 4'd1;
  localparam ST_RS_SCL = 4'd2;
  localparam ST_RS_HI  = 4'd3;
  localparam ST_RS_SDA = 4'd4;
  localparam ST_SP_SDA = 4'd5;
  localparam ST_SP_SCL = 4'd6;
  localparam ST_SP_CNT = 4'd7;
  localparam ST_SP_REL = 4'd8;
  localparam ST_XFER   = 4'd9;

  // Open-drain pins only ever drive low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // Three-stage input synchronisers; value accepted when stages 2 and 3 agree
  reg [2:0] sclSync;
  reg [2:0] sdaSync;
  reg       sclHigh;
  reg       sdaHigh;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sclSync <= 3'b111;
      sdaSync <= 3'b111;
      sclHigh <= 1'b1;
      sdaHigh <= 1'b1;
    end else begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
      if (sclSync[1] == sclSync[2])
        sclHigh <= sclSync[2];
      if (sdaSync[1] == sdaSync[2])
        sdaHigh <= sdaSync[2];
    end
  end

  // Registers
  reg [BAUD_W-1:0] baudReloadValue;
  reg [7:0]        txRxBuffer;
  reg              bufferFull;
  reg              seqRestart;
  reg              seqStop;
  reg              stopSeen;
  reg [2:0]        irqStat;
  reg [2:0]        irqMask;
  reg [3:0]        state;
  reg              sclPrev;

  // Baud generator control
  reg  brgReload;
  wire brgExpRaw;
  // A reload issued on the last edge has not yet cleared the old expiry; mask it
  wire brgExpired = brgExpRaw && !brgReload;
  wire brgRun = (state != ST_IDLE);

  // Shared divider for every mode, reloaded each half period
  i2cbr_baud_counter #(.WIDTH(BAUD_W)) uBaud (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .reload      (brgReload),
    .run         (brgRun),
    .reloadValue (baudReloadValue),
    .expired     (brgExpRaw)
  );

  // AXI write channel: take address and data in either order
  reg        awHeld;
  reg        wHeld;
  reg [7:0]  awAddr;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  wire       wrFire = awHeld && wHeld && !s_axi_bvalid;

  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a == `I2CBR_ADDR_RELOAD) || (a == `I2CBR_ADDR_CONTROL) ||
                 (a == `I2CBR_ADDR_STATUS) || (a == `I2CBR_ADDR_IRQSTAT) ||
                 (a == `I2CBR_ADDR_IRQMASK) || (a == `I2CBR_ADDR_BUFFER);
    end
  endfunction

  wire wrCtl  = wrFire && awAddr == `I2CBR_ADDR_CONTROL && wStrb[0];
  wire wrBuf  = wrFire && awAddr == `I2CBR_ADDR_BUFFER && wStrb[0];
  wire wrIrqS = wrFire && awAddr == `I2CBR_ADDR_IRQSTAT && wStrb[0];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0000_0000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `I2CBR_AXI_OKAY;
      baudReloadValue <= `I2CBR_RELOAD_RST;
      irqMask      <= 3'b000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr) ? `I2CBR_AXI_OKAY : `I2CBR_AXI_SLVERR;
        if (awAddr == `I2CBR_ADDR_RELOAD && wStrb[0])
          baudReloadValue <= wData[BAUD_W-1:0];
        if (awAddr == `I2CBR_ADDR_IRQMASK && wStrb[0])
          irqMask <= wData[2:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel, one read in flight
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] portStatus = {3'b000, stopSeen, 1'b0, seqStop, seqRestart, bufferFull};
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `I2CBR_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= isMapped(s_axi_araddr) ? `I2CBR_AXI_OKAY : `I2CBR_AXI_SLVERR;
      case (s_axi_araddr)
        `I2CBR_ADDR_RELOAD:  s_axi_rdata <= {{(32-BAUD_W){1'b0}}, baudReloadValue};
        `I2CBR_ADDR_CONTROL: s_axi_rdata <= {30'h0000_0000, seqStop, seqRestart};
        `I2CBR_ADDR_STATUS:  s_axi_rdata <= {24'h00_0000, portStatus};
        `I2CBR_ADDR_IRQSTAT: s_axi_rdata <= {29'h0000_0000, irqStat};
        `I2CBR_ADDR_IRQMASK: s_axi_rdata <= {29'h0000_0000, irqMask};
        `I2CBR_ADDR_BUFFER:  s_axi_rdata <= {24'h00_0000, txRxBuffer};
        default:             s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer: events raised here feed the sticky interrupt bits
  reg collision;
  reg seqDone;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      sclOe      <= 1'b0;
      sdaOe      <= 1'b0;
      seqRestart <= 1'b0;
      seqStop    <= 1'b0;
      stopSeen   <= 1'b0;
      bufferFull <= 1'b0;
      txRxBuffer <= 8'h00;
      brgReload  <= 1'b0;
      collision  <= 1'b0;
      seqDone    <= 1'b0;
      sclPrev    <= 1'b1;
    end else begin
      brgReload <= 1'b0;
      collision <= 1'b0;
      seqDone   <= 1'b0;
      sclPrev   <= sclHigh;
      case (state)
        ST_IDLE: begin
          // Pins stay at their last level while idle
          if (wrCtl && wData[`I2CBR_CTL_RSTART]) begin
            seqRestart <= 1'b1;
            sdaOe      <= 1'b0;
            brgReload  <= 1'b1;
            state      <= ST_RS_CNT;
          end else if (wrCtl && wData[`I2CBR_CTL_STOP]) begin
            seqStop  <= 1'b1;
            stopSeen <= 1'b0;
            sdaOe    <= 1'b1;
            state    <= ST_SP_SDA;
          end else if (wrBuf) begin
            txRxBuffer <= wData[7:0];
            bufferFull <= 1'b1;
            brgReload  <= 1'b1;
            state      <= ST_XFER;
          end
        end
        ST_XFER: begin
          // No byte is shifted anywhere in the design; one half period marks completion
          if (brgExpired) begin
            bufferFull <= 1'b0;
            seqDone    <= 1'b1;
            state      <= ST_IDLE;
          end
        end
        ST_RS_CNT: if (brgExpired) begin
          sclOe <= 1'b0;
          state <= ST_RS_SCL;
        end
        ST_RS_SCL: if (sclHigh) begin
          if (!sdaHigh) begin
            collision <= 1'b1;
          end else begin
            brgReload <= 1'b1;
            state     <= ST_RS_HI;
          end
        end
        ST_RS_HI: begin
          if (sclPrev && !sclHigh && sdaHigh)
            collision <= 1'b1;
          else if (brgExpired && sclHigh && sdaHigh) begin
            sdaOe     <= 1'b1;
            brgReload <= 1'b1;
            state     <= ST_RS_SDA;
          end else if (brgExpired) begin
            // SDA pulled early by another master: no collision, proceed
            sdaOe     <= 1'b1;
            brgReload <= 1'b1;
            state     <= ST_RS_SDA;
          end
        end
        ST_RS_SDA: if (brgExpired) begin
          sclOe      <= 1'b1;
          seqRestart <= 1'b0;
          seqDone    <= 1'b1;
          state      <= ST_IDLE;
        end
        ST_SP_SDA: if (!sdaHigh) begin
          sclOe <= 1'b0;
          state <= ST_SP_SCL;
        end
        ST_SP_SCL: if (sclHigh) begin
          brgReload <= 1'b1;
          state     <= ST_SP_CNT;
        end
        ST_SP_CNT: begin
          if (!sclHigh)
            collision <= 1'b1;
          else if (brgExpired) begin
            sdaOe     <= 1'b0;
            brgReload <= 1'b1;
            state     <= ST_SP_REL;
          end
        end
        ST_SP_REL: if (brgExpired) begin
          if (!sdaHigh)
            collision <= 1'b1;
          else begin
            stopSeen <= 1'b1;
            seqStop  <= 1'b0;
            seqDone  <= 1'b1;
            state    <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Abort on collision: release both lines, clear enables, go idle
      if (collision) begin
        sclOe      <= 1'b0;
        sdaOe      <= 1'b0;
        seqRestart <= 1'b0;
        seqStop    <= 1'b0;
        bufferFull <= 1'b0;
        state      <= ST_IDLE;
      end
    end
  end

  // Sticky interrupt status; a new event beats a simultaneous clear
  wire [2:0] irqEvents = {wrBuf && state != ST_IDLE, seqDone, collision};
  always @(posedge clk_sys) begin
    if (!rst_n)
      irqStat <= 3'b000;
    else
      irqStat <= (irqStat & ~(wrIrqS ? wData[2:0] : 3'b000)) | irqEvents;
  end
  assign irq = |(irqStat & irqMask);
endmodule

//--- dv/i2cbr_bus_model.sv
`timescale 1ns/1ps
// Other masters and slaves on the shared open drain bus
module i2cbr_bus_model (
  // Device side
  input  logic sclOut,
  input  logic sclOe,
  input  logic sdaOut,
  input  logic sdaOe,
  // Pulls by another master, set by the bench
  input  logic sclPull,
  input  logic sdaPull,
  // Wire levels
  output logic sclIn,
  output logic sdaIn
);
  // Released lines float high on their pull ups; any low driver wins
  assign sclIn = (sclOe ? sclOut : 1'b1) & !sclPull;
  assign sdaIn = (sdaOe ? sdaOut : 1'b1) & !sdaPull;
endmodule

//--- dv/i2cbr_master_chk.sv
`timescale 1ns/1ps
// Pin and bus relations of the sequencer, seen from the ports
module i2cbr_master_chk (
  // Clock and reset
  input logic        clk_sys,
  input logic        rst_n,
  // Register bus
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Bus pins
  input logic        sclIn,
  input logic        sclOe,
  input logic        sdaOe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Answers stand until taken
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Repeated start pulls SDA only with SCL high, holds a full count, then pulls SCL
  rs_drive_a: assert property ($rose(sdaOe) && !sclOe |-> $past(sclIn, 4))
    else $error("SDA pulled with SCL low");
  rs_hold_a: assert property ($rose(sdaOe) && !sclOe |=> sdaOe [*8])
    else $error("SDA released early");
  rs_end_a: assert property ($rose(sdaOe) && !sclOe |-> ##[8:1000] sclOe)
    else $error("SCL not pulled after start");
  // Minimum supported reload gives at least eight cycles per half period
  scl_rel_a: assert property ($fell(sclOe) |=> !sclOe [*8])
    else $error("SCL half period short");
  stop_end_a: assert property ($fell(sclOe) && sdaOe |-> ##[1:1000] !sdaOe)
    else $error("SDA never released in stop");
endmodule

bind i2cbr_master i2cbr_master_chk i2cbr_master_chk_i (
  .clk_sys, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sclIn, .sclOe, .sdaOe
);

//--- dv/tb_i2c_master_collision_brg.sv
`timescale 1ns/1ps
`include "i2cbr_map.vh"
module tb_i2c_master_collision_brg;
  logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, sclPull, sdaPull;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         sclIn, sdaIn, sclOut, sdaOut, sclOe, sdaOe, irq;
  logic [33:0] expQ[$], mskQ[$];
  int          fails, n_checks, cyc, seed, r, n;

  i2cbr_master #(.BAUD_W(8)) i2cbr_master_i (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sclOut, .sclOe, .sdaIn,
    .sdaOut, .sdaOe, .irq);
  i2cbr_bus_model i2cbr_bus_model_i (.sclOut, .sclOe, .sdaOut, .sdaOe, .sclPull, .sdaPull, .sclIn, .sdaIn);

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask

  // Expected answer is noted first; the monitor compares it
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] p = 2'h0,
                     input logic [31:0] m = 32'hffffffff);
    @(posedge clk_sys);
    expQ.push_back({p, e & m});
    mskQ.push_back({2'h3, m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask

  // Monitor: each read answer against the oldest note
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata} & mskQ[0], expQ[0]);
      void'(expQ.pop_front());
      void'(mskQ.pop_front());
    end
  end

  task automatic waitIrq();
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // Let the interrupt level settle before looking at it
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk_sys);
    chk(34'(irq), 34'(e));
  endtask

  // One sequence; another master holds SDA from the start or pulses a line at dly
  task automatic seq(input logic [1:0] c, input bit sda, input int dly, input logic [31:0] e);
    sdaPull <= sda && dly == 0;
    axw(`I2CBR_ADDR_CONTROL, {30'h0, c});
    if (dly > 0) begin
      repeat (dly) @(posedge clk_sys);
      sdaPull <= sda;
      sclPull <= !sda;
      repeat (3) @(posedge clk_sys);
      sdaPull <= 1'b0;
      sclPull <= 1'b0;
    end
    waitIrq();
    axr(`I2CBR_ADDR_IRQSTAT, e);
    axr(`I2CBR_ADDR_CONTROL, 32'h0);
    sdaPull <= 1'b0;
    axw(`I2CBR_ADDR_IRQSTAT, 32'h3);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end

  initial begin
    seed = 32'h9fbb69fa;
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h0;
    {sclPull, sdaPull, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 54'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    axr(`I2CBR_ADDR_RELOAD, `I2CBR_RELOAD_RST);
    axr(8'h1c, 32'h0, `I2CBR_AXI_SLVERR);
    r = 3 + ($random(seed) & 7);
    axw(`I2CBR_ADDR_RELOAD, r);
    axw(`I2CBR_ADDR_RELOAD, 32'hff, 4'he);
    axr(`I2CBR_ADDR_RELOAD, r);
    axw(`I2CBR_ADDR_IRQMASK, 32'h3);
    $display("register test done");
    axw(`I2CBR_ADDR_BUFFER, $random(seed) & 32'hff);
    waitIrq();
    chk(34'(n >= 2 * r - 1 && n <= 2 * r + 6), 34'h1);
    axr(`I2CBR_ADDR_IRQSTAT, 32'h2);
    axw(`I2CBR_ADDR_IRQSTAT, 32'h2);
    irqIs(1'b0);
    axw(`I2CBR_ADDR_IRQMASK, 32'h0);
    axw(`I2CBR_ADDR_BUFFER, $random(seed) & 32'hff);
    repeat (2 * r + 12) @(posedge clk_sys);
    irqIs(1'b0);
    axr(`I2CBR_ADDR_IRQSTAT, 32'h2);
    axw(`I2CBR_ADDR_IRQMASK, 32'h3);
    irqIs(1'b1);
    axw(`I2CBR_ADDR_IRQSTAT, 32'h2);
    irqIs(1'b0);
    $display("baud and interrupt test done");
    seq(2'h1, 1'b0, 0, 32'h2);
    chk(34'(sclOe), 34'h1);
    seq(2'h2, 1'b0, 0, 32'h2);
    chk(34'({sclOe, sdaOe}), 34'h0);
    axr(`I2CBR_ADDR_STATUS, 32'h10, 2'h0, 32'h16);
    seq(2'h1, 1'b1, 0, 32'h1);
    chk(34'({sclOe, sdaOe}), 34'h0);
    seq(2'h1, 1'b0, 3 * r, 32'h1);
    seq(2'h1, 1'b1, 3 * r, 32'h2);
    seq(2'h2, 1'b1, 0, 32'h1);
    seq(2'h1, 1'b0, 0, 32'h2);
    seq(2'h2, 1'b0, r + 3, 32'h1);
    $display("collision test done");
    end_sim;
  end
endmodule
